//--- logic/core_bus_pkg.sv
`default_nettype none
package core_bus_pkg;
	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int MIN_CYCLES = 4;
	// Acknowledge goes out two clocks after the strobe is seen, so the core ends no sooner than the fourth.
	localparam int ACK_FLOOR = MIN_CYCLES - 3;
	localparam int END_WINDOW = 2;
	localparam int RESET_INIT_CLKS = 132;
	localparam int RESET_LATER_CLKS = 10;
	// ************************************************************
	// Widths
	// ************************************************************
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int WAIT_W = 4;
	localparam int CNT_W = 6;
	localparam int LVL_W = 3;
	localparam int NCS = 4;
	localparam int CS_IDX_W = 2;
	localparam int MA_W = 11;
	// ************************************************************
	// Address map
	// ************************************************************
	localparam int REGION_HI = 23;
	localparam int REGION_LO = 21;
	localparam logic [2:0] REGION_REGS = 3'h7;
	localparam logic [2:0] REGION_DRAM_MIN = 3'h4;
	localparam int BANK_HI = 22;
	localparam int BANK_LO = 21;
	localparam int ROW_HI = 21;
	localparam int ROW_LO = 11;
	localparam int COL_HI = 10;
	localparam int COL_LO = 1;
	localparam logic [2:0] FC_IACK = 3'h7;
	localparam logic [2:0] FC_SUP_PROG = 3'h6;
	localparam logic [19:0] IACK_HIGH = 20'hfffff;
	localparam logic [23:0] VEC_SSP_ADDR = 24'h000000;
	localparam logic [23:0] VEC_PC_ADDR = 24'h000004;
	localparam logic [2:0] IPL_MASK_RESET = 3'h7;
	localparam logic [1:0] LANES_WORD = 2'h3;
	localparam logic [1:0] LANE_UPPER = 2'h2;
	localparam logic [1:0] LANE_LOWER = 2'h1;
	// ************************************************************
	// State types
	// ************************************************************
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ACK} cyc_state_t;
	typedef enum logic [2:0] {DR_IDLE, DR_ROW, DR_COL, DR_HOLD, DR_DONE} dram_state_t;
endpackage : core_bus_pkg
`default_nettype wire

//--- logic/dram_write_port.sv
`timescale 1ns/100ps
`default_nettype none
module dram_write_port #(
	parameter int NRAS = 6
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic push,
	input wire logic [core_bus_pkg::ADDR_W-1:0] push_addr,
	input wire logic [core_bus_pkg::DATA_W-1:0] push_data,
	input wire logic [1:0] push_lanes,
	output logic full,
	input wire logic rd_req,
	input wire logic [core_bus_pkg::ADDR_W-1:0] rd_addr,
	output logic rd_done,
	output logic [core_bus_pkg::DATA_W-1:0] rd_data,
	input wire logic gbus_busy,
	output logic [NRAS-1:0] dram_row_strobes_n,
	output logic [1:0] dram_column_strobes_n,
	output logic [core_bus_pkg::MA_W-1:0] dram_mux_address,
	output logic dram_we_n,
	output logic [core_bus_pkg::DATA_W-1:0] dram_data_out,
	output logic dram_data_oe,
	input wire logic [core_bus_pkg::DATA_W-1:0] dram_data_bus_in
);
	import core_bus_pkg::*;

	dram_state_t state_r;
	logic [ADDR_W-1:0] ent_addr_r;
	logic [ADDR_W-1:0] rd_addr_r;
	logic [DATA_W-1:0] ent_data_r;
	logic [1:0] ent_lanes_r;
	logic rd_pend_r;
	logic cur_write_r;
	logic [DATA_W-1:0] din_s1_r;
	logic [DATA_W-1:0] din_s2_r;

	wire start_ok = (state_r == DR_IDLE) && !gbus_busy && (full || rd_pend_r);
	wire [ADDR_W-1:0] use_addr = full ? ent_addr_r : rd_addr_r;
	wire [1:0] bank = use_addr[BANK_HI:BANK_LO];
	wire [MA_W-1:0] row_addr = use_addr[ROW_HI:ROW_LO];
	wire [MA_W-1:0] col_addr = {1'b0, use_addr[COL_HI:COL_LO]};
	wire [1:0] col_lanes = cur_write_r ? ent_lanes_r : LANES_WORD;
	wire wr_done = (state_r == DR_DONE) && cur_write_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			din_s1_r <= '0;
			din_s2_r <= '0;
		end else begin
			din_s1_r <= dram_data_bus_in;
			din_s2_r <= din_s1_r;
		end
	end

	// ************************************************************
	// Single-entry posted write buffer
	// ************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			full <= 1'b0;
			ent_addr_r <= '0;
			ent_data_r <= '0;
			ent_lanes_r <= '0;
			rd_pend_r <= 1'b0;
			rd_addr_r <= '0;
		end else begin
			full <= push | (full & ~wr_done);
			if (push) begin
				ent_addr_r <= push_addr;
				ent_data_r <= push_data;
				ent_lanes_r <= push_lanes;
			end
			rd_pend_r <= rd_req | (rd_pend_r & ~(start_ok && !full));
			if (rd_req) begin
				rd_addr_r <= rd_addr;
			end
		end
	end

	// ************************************************************
	// Graphics bus sequencer
	// ************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= DR_IDLE;
			cur_write_r <= 1'b0;
			rd_done <= 1'b0;
			rd_data <= '0;
			dram_row_strobes_n <= '1;
			dram_column_strobes_n <= '1;
			dram_mux_address <= '0;
			dram_we_n <= 1'b1;
			dram_data_out <= '0;
			dram_data_oe <= 1'b0;
		end else begin
			rd_done <= 1'b0;
			case (state_r)
				DR_IDLE: if (start_ok) begin
					cur_write_r <= full;
					dram_mux_address <= row_addr;
					dram_row_strobes_n[bank] <= 1'b0;
					dram_we_n <= ~full;
					dram_data_oe <= full;
					dram_data_out <= ent_data_r;
					state_r <= DR_ROW;
				end
				DR_ROW: begin
					dram_mux_address <= col_addr;
					dram_column_strobes_n <= ~col_lanes;
					state_r <= DR_COL;
				end
				DR_COL: state_r <= DR_HOLD;
				DR_HOLD: state_r <= DR_DONE;
				DR_DONE: begin
					if (!cur_write_r) begin
						rd_data <= din_s2_r;
						rd_done <= 1'b1;
					end
					dram_row_strobes_n <= '1;
					dram_column_strobes_n <= '1;
					dram_we_n <= 1'b1;
					dram_data_oe <= 1'b0;
					state_r <= DR_IDLE;
				end
				default: state_r <= DR_IDLE;
			endcase
		end
	end

	property p_full_clears;
		@(posedge clk) disable iff (!rst_n) wr_done |=> !full;
	endproperty
	a_full_clears: assert property (p_full_clears) else $error("buffer still full after its write");

	property p_bus_free_start;
		@(posedge clk) disable iff (!rst_n) (state_r == DR_IDLE) && full && !gbus_busy |=> !(&dram_row_strobes_n) && !dram_we_n;
	endproperty
	a_bus_free_start: assert property (p_bus_free_start) else $error("buffered write not started on free bus");
endmodule : dram_write_port
`default_nettype wire

//--- logic/core_bus_cycle_control.sv
`timescale 1ns/100ps
`default_nettype none
module core_bus_cycle_control #(
	parameter int NSRC = 8,
	parameter int NRAS = 6
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic core_as_n,
	input wire logic core_rw,
	input wire logic core_byte,
	input wire logic [2:0] core_fc,
	input wire logic [core_bus_pkg::ADDR_W-1:0] core_addr,
	input wire logic [core_bus_pkg::DATA_W-1:0] core_wdata,
	output logic [core_bus_pkg::DATA_W-1:0] core_rdata,
	output logic transfer_ack_n,
	output logic autovector_ack_n,
	output logic [core_bus_pkg::LVL_W-1:0] interrupt_level_request_n,
	output logic [core_bus_pkg::LVL_W-1:0] status_ipl_mask,
	output logic [31:0] boot_ssp,
	output logic [31:0] boot_pc,
	output logic core_run,
	input wire logic [core_bus_pkg::NCS*core_bus_pkg::WAIT_W-1:0] cs_wait,
	output logic [core_bus_pkg::ADDR_W-1:0] ext_addr,
	output logic [core_bus_pkg::NCS-1:0] chip_select_n,
	output logic address_strobe_n,
	output logic read_strobe_n,
	output logic upper_write_strobe_n,
	output logic lower_write_strobe_n,
	output logic [core_bus_pkg::DATA_W-1:0] ext_data_out,
	output logic ext_data_oe,
	input wire logic [core_bus_pkg::DATA_W-1:0] ext_data_in,
	output logic reg_strobe,
	output logic reg_write,
	input wire logic [core_bus_pkg::DATA_W-1:0] reg_rdata,
	input wire logic ext_irq_n,
	input wire logic [NSRC-1:0] irq_event,
	input wire logic [(NSRC+1)*core_bus_pkg::LVL_W-1:0] irq_level,
	input wire logic [NSRC:0] event_clear,
	output logic [NSRC:0] event_bits,
	input wire logic gbus_busy,
	output logic [NRAS-1:0] dram_row_strobes_n,
	output logic [1:0] dram_column_strobes_n,
	output logic [core_bus_pkg::MA_W-1:0] dram_mux_address,
	output logic dram_we_n,
	output logic [core_bus_pkg::DATA_W-1:0] dram_data_out,
	output logic dram_data_oe,
	input wire logic [core_bus_pkg::DATA_W-1:0] dram_data_bus_in
);
	import core_bus_pkg::*;

	// ************************************************************
	// Reset release and pin synchronisers
	// ************************************************************
	// Only the pin resets the block; the reset instruction has no path in here at all.
	logic rst_s1_r;
	logic rst_n_s;
	logic [DATA_W-1:0] din_s1_r;
	logic [DATA_W-1:0] din_s2_r;
	logic irq_s1_r;
	logic irq_s2_r;
	logic irq_s3_r;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_s1_r <= 1'b0;
			rst_n_s <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_s <= rst_s1_r;
		end
	end

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			din_s1_r <= '0;
			din_s2_r <= '0;
			irq_s1_r <= 1'b1;
			irq_s2_r <= 1'b1;
			irq_s3_r <= 1'b1;
		end else begin
			din_s1_r <= ext_data_in;
			din_s2_r <= din_s1_r;
			irq_s1_r <= ext_irq_n;
			irq_s2_r <= irq_s1_r;
			irq_s3_r <= irq_s2_r;
		end
	end

	// ************************************************************
	// Request selection and address decode
	// ************************************************************
	cyc_state_t state_r;
	logic boot_act_r;
	logic [1:0] boot_phase_r;
	logic [ADDR_W-1:0] addr_r;
	logic rw_r;
	logic byte_r;
	logic is_cs_r;
	logic is_dram_r;
	logic is_reg_r;
	logic is_iack_r;
	logic [CS_IDX_W-1:0] cs_idx_r;
	logic [DATA_W-1:0] wdata_r;
	logic [CNT_W-1:0] cnt_r;
	logic rd_issued_r;
	logic dram_done_r;
	logic wb_push_r;
	logic wb_rd_req_r;
	logic wb_full;
	logic wb_rd_done;
	logic [DATA_W-1:0] wb_rd_data;

	wire [ADDR_W-1:0] boot_addr = (boot_phase_r[1] ? VEC_PC_ADDR : VEC_SSP_ADDR) | {22'h0, boot_phase_r[0], 1'b0};
	wire start = boot_act_r | (core_run & ~core_as_n);
	wire end_ok = boot_act_r | core_as_n;
	wire [ADDR_W-1:0] req_addr = boot_act_r ? boot_addr : core_addr;
	wire req_rw = boot_act_r | core_rw;
	wire req_byte = ~boot_act_r & core_byte;
	wire [2:0] req_region = req_addr[REGION_HI:REGION_LO];
	wire dec_iack = ~boot_act_r && (core_fc == FC_IACK) && (core_addr[23:4] == IACK_HIGH) && core_addr[0];
	wire dec_reg = ~dec_iack && (req_region == REGION_REGS);
	wire dec_dram = ~dec_iack && (req_region >= REGION_DRAM_MIN) && !dec_reg;
	wire dec_cs = ~dec_iack && !dec_reg && !dec_dram;
	wire [1:0] req_lanes = !req_byte ? LANES_WORD : (req_addr[0] ? LANE_LOWER : LANE_UPPER);
	wire [NCS-1:0] cs_onehot = NCS'(1) << req_region[CS_IDX_W-1:0];

	// ************************************************************
	// Wait pacing and data placement
	// ************************************************************
	wire [WAIT_W-1:0] wait_sel = cs_wait[cs_idx_r*WAIT_W +: WAIT_W];
	wire floor_ok = cnt_r >= CNT_W'(ACK_FLOOR);
	// Pin data spends two clocks in the synchroniser, so chip-select data needs one clock beyond the floor.
	wire cs_ok = cnt_r > (CNT_W'(ACK_FLOOR) + CNT_W'(wait_sel));
	wire dram_ok = rw_r ? dram_done_r : !wb_full;
	wire ready = floor_ok && (is_cs_r ? cs_ok : (is_dram_r ? dram_ok : 1'b1));
	wire [DATA_W-1:0] cap_src = is_dram_r ? wb_rd_data : (is_reg_r ? reg_rdata : din_s2_r);
	wire [DATA_W-1:0] cap_byte = addr_r[0] ? {8'h00, cap_src[7:0]} : {8'h00, cap_src[15:8]};
	wire [DATA_W-1:0] cap_data = byte_r ? cap_byte : cap_src;
	wire in_wait = state_r == ST_WAIT;
	wire in_idle = state_r == ST_IDLE;

	// ************************************************************
	// Cycle sequencer
	// ************************************************************
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			state_r <= ST_IDLE;
			boot_act_r <= 1'b1;
			boot_phase_r <= '0;
			core_run <= 1'b0;
			boot_ssp <= '0;
			boot_pc <= '0;
			addr_r <= '0;
			rw_r <= 1'b1;
			byte_r <= 1'b0;
			is_cs_r <= 1'b0;
			is_dram_r <= 1'b0;
			is_reg_r <= 1'b0;
			is_iack_r <= 1'b0;
			cs_idx_r <= '0;
			wdata_r <= '0;
			cnt_r <= '0;
			rd_issued_r <= 1'b0;
			dram_done_r <= 1'b0;
			wb_push_r <= 1'b0;
			wb_rd_req_r <= 1'b0;
			core_rdata <= '0;
			transfer_ack_n <= 1'b1;
			autovector_ack_n <= 1'b1;
			ext_addr <= '0;
			chip_select_n <= '1;
			address_strobe_n <= 1'b1;
			read_strobe_n <= 1'b1;
			upper_write_strobe_n <= 1'b1;
			lower_write_strobe_n <= 1'b1;
			ext_data_out <= '0;
			ext_data_oe <= 1'b0;
			reg_strobe <= 1'b0;
			reg_write <= 1'b0;
		end else begin
			reg_strobe <= 1'b0;
			wb_push_r <= 1'b0;
			wb_rd_req_r <= 1'b0;
			case (state_r)
				ST_IDLE: if (start) begin
					addr_r <= req_addr;
					rw_r <= req_rw;
					byte_r <= req_byte;
					is_cs_r <= dec_cs;
					is_dram_r <= dec_dram;
					is_reg_r <= dec_reg;
					is_iack_r <= dec_iack;
					cs_idx_r <= req_region[CS_IDX_W-1:0];
					wdata_r <= core_wdata;
					cnt_r <= '0;
					rd_issued_r <= 1'b0;
					dram_done_r <= 1'b0;
					state_r <= ST_WAIT;
					if (dec_cs || dec_reg) begin
						ext_addr <= req_addr;
						ext_data_out <= core_wdata;
					end
					if (dec_cs) begin
						chip_select_n <= ~cs_onehot;
						address_strobe_n <= 1'b0;
						read_strobe_n <= ~req_rw;
						upper_write_strobe_n <= ~(~req_rw & req_lanes[1]);
						lower_write_strobe_n <= ~(~req_rw & req_lanes[0]);
						ext_data_oe <= ~req_rw;
					end
					reg_strobe <= dec_reg;
					reg_write <= dec_reg & ~req_rw;
				end
				ST_WAIT: begin
					cnt_r <= (&cnt_r) ? cnt_r : cnt_r + 1'b1;
					if (is_dram_r && rw_r && !rd_issued_r && !wb_full) begin
						wb_rd_req_r <= 1'b1;
						rd_issued_r <= 1'b1;
					end
					if (wb_rd_done) begin
						dram_done_r <= 1'b1;
					end
					if (ready) begin
						state_r <= ST_ACK;
						core_rdata <= cap_data;
						wb_push_r <= is_dram_r & ~rw_r;
						if (is_iack_r) begin
							autovector_ack_n <= 1'b0;
						end else if (!boot_act_r) begin
							transfer_ack_n <= 1'b0;
						end
					end
				end
				ST_ACK: if (end_ok) begin
					state_r <= ST_IDLE;
					transfer_ack_n <= 1'b1;
					autovector_ack_n <= 1'b1;
					chip_select_n <= '1;
					address_strobe_n <= 1'b1;
					read_strobe_n <= 1'b1;
					upper_write_strobe_n <= 1'b1;
					lower_write_strobe_n <= 1'b1;
					ext_data_oe <= 1'b0;
					if (boot_act_r) begin
						boot_phase_r <= boot_phase_r + 1'b1;
						case (boot_phase_r)
							2'd0: boot_ssp[31:16] <= core_rdata;
							2'd1: boot_ssp[15:0] <= core_rdata;
							2'd2: boot_pc[31:16] <= core_rdata;
							default: boot_pc[15:0] <= core_rdata;
						endcase
						if (&boot_phase_r) begin
							boot_act_r <= 1'b0;
							core_run <= 1'b1;
						end
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	dram_write_port #(.NRAS(NRAS)) u_dram (
		.clk(clk),
		.rst_n(rst_n_s),
		.push(wb_push_r),
		.push_addr(addr_r),
		.push_data(wdata_r),
		.push_lanes(byte_r ? (addr_r[0] ? LANE_LOWER : LANE_UPPER) : LANES_WORD),
		.full(wb_full),
		.rd_req(wb_rd_req_r),
		.rd_addr(addr_r),
		.rd_done(wb_rd_done),
		.rd_data(wb_rd_data),
		.gbus_busy(gbus_busy),
		.dram_row_strobes_n(dram_row_strobes_n),
		.dram_column_strobes_n(dram_column_strobes_n),
		.dram_mux_address(dram_mux_address),
		.dram_we_n(dram_we_n),
		.dram_data_out(dram_data_out),
		.dram_data_oe(dram_data_oe),
		.dram_data_bus_in(dram_data_bus_in)
	);

	// ************************************************************
	// Interrupt events and level request
	// ************************************************************
	wire [NSRC:0] src_set = {irq_event, irq_s3_r & ~irq_s2_r};
	logic [LVL_W-1:0] max_lvl;

	genvar g;
	generate
		for (g = 0; g <= NSRC; g++) begin : g_event
			always_ff @(posedge clk or negedge rst_n_s) begin
				if (!rst_n_s) begin
					event_bits[g] <= 1'b0;
				end else begin
					event_bits[g] <= src_set[g] | (event_bits[g] & ~event_clear[g]);
				end
			end
		end
	endgenerate

	always_comb begin
		max_lvl = '0;
		for (int i = 0; i <= NSRC; i++) begin
			if (event_bits[i] && (irq_level[i*LVL_W +: LVL_W] > max_lvl)) begin
				max_lvl = irq_level[i*LVL_W +: LVL_W];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			interrupt_level_request_n <= '1;
			status_ipl_mask <= IPL_MASK_RESET;
		end else begin
			interrupt_level_request_n <= ~max_lvl;
			status_ipl_mask <= status_ipl_mask;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	logic wait_d1_r;
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			wait_d1_r <= 1'b0;
		end else begin
			wait_d1_r <= in_wait;
		end
	end

	property p_min_cycle;
		@(posedge clk) disable iff (!rst_n_s) $fell(transfer_ack_n) |-> wait_d1_r && $past(wait_d1_r, 1);
	endproperty
	a_min_cycle: assert property (p_min_cycle) else $error("acknowledge earlier than four clocks");

	property p_as_cs_only;
		@(posedge clk) disable iff (!rst_n_s) !address_strobe_n |-> is_cs_r && (chip_select_n != '1);
	endproperty
	a_as_cs_only: assert property (p_as_cs_only) else $error("address strobe outside chip-select cycle");

	property p_byte_lane;
		@(posedge clk) disable iff (!rst_n_s) !in_idle && is_cs_r && !rw_r && byte_r |->
			(upper_write_strobe_n == addr_r[0]) && (lower_write_strobe_n == !addr_r[0]);
	endproperty
	a_byte_lane: assert property (p_byte_lane) else $error("wrong write strobe for byte lane");

	property p_byte_read;
		@(posedge clk) disable iff (!rst_n_s) $rose(state_r == ST_ACK) && is_cs_r && rw_r && byte_r |->
			core_rdata == (addr_r[0] ? {8'h00, $past(din_s2_r[7:0])} : {8'h00, $past(din_s2_r[15:8])});
	endproperty
	a_byte_read: assert property (p_byte_read) else $error("byte read placed wrongly");

	property p_word_read;
		@(posedge clk) disable iff (!rst_n_s) $rose(state_r == ST_ACK) && is_cs_r && rw_r && !byte_r |->
			core_rdata == $past(din_s2_r);
	endproperty
	a_word_read: assert property (p_word_read) else $error("word read lost a byte");

	property p_wb_zero_wait;
		@(posedge clk) disable iff (!rst_n_s) in_idle && start && dec_dram && !req_rw && !wb_full |-> ##3 !transfer_ack_n;
	endproperty
	a_wb_zero_wait: assert property (p_wb_zero_wait) else $error("buffered write not acknowledged in minimum time");

	property p_full_stall;
		@(posedge clk) disable iff (!rst_n_s) in_wait && is_dram_r && !rw_r && wb_full |=> transfer_ack_n;
	endproperty
	a_full_stall: assert property (p_full_stall) else $error("write acknowledged into full buffer");

	property p_autovector_ack_n_release;
		@(posedge clk) disable iff (!rst_n_s) !autovector_ack_n && core_as_n |=> autovector_ack_n && transfer_ack_n;
	endproperty
	a_autovector_ack_n_release: assert property (p_autovector_ack_n_release) else $error("autovector held after strobe released");

	property p_level_hold;
		@(posedge clk) disable iff (!rst_n_s) (event_clear == '0) && ($past(event_clear) == '0) && $stable(irq_level) |=>
			(~interrupt_level_request_n) >= $past(~interrupt_level_request_n);
	endproperty
	a_level_hold: assert property (p_level_hold) else $error("level request dropped without a clear");

	property p_boot_fetch;
		@(posedge clk) disable iff (!rst_n_s) $rose(rst_n_s) |-> ##1 (ext_addr == VEC_SSP_ADDR) && !chip_select_n[0]
			&& (status_ipl_mask == IPL_MASK_RESET);
	endproperty
	a_boot_fetch: assert property (p_boot_fetch) else $error("boot fetch not at stack vector");

	c_cs_read: cover property (@(posedge clk) disable iff (!rst_n_s) $fell(transfer_ack_n) && is_cs_r && rw_r);
	c_dram_write: cover property (@(posedge clk) disable iff (!rst_n_s) wb_push_r);
	c_full_stall: cover property (@(posedge clk) disable iff (!rst_n_s) in_wait && is_dram_r && !rw_r && wb_full);
	c_iack: cover property (@(posedge clk) disable iff (!rst_n_s) $fell(autovector_ack_n));
endmodule : core_bus_cycle_control
`default_nettype wire

//--- verification/mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module mem_model (
	input wire logic clk,
	input wire logic [23:0] ext_addr,
	input wire logic [3:0] chip_select_n,
	input wire logic read_strobe_n,
	output logic [15:0] ext_data_in,
	output logic [15:0] dram_data_bus_in
);
	logic [15:0] word;
	// A sixteen-bit device never sees A0, so both byte lanes come from one word.
	assign word = {ext_addr[15:1], 1'b0} ^ 16'h5a3c;
	// A deselected device shows the inverse word, so a late sample never matches by luck.
	assign ext_data_in = (!read_strobe_n && chip_select_n != 4'hf) ? word : ~word;
	initial begin
		dram_data_bus_in = 16'h0000;
		forever @(posedge clk) dram_data_bus_in <= ~dram_data_bus_in;
	end
endmodule : mem_model
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import core_bus_pkg::*;
	logic clk, reset_n, core_as_n, core_rw, core_byte, ext_irq_n, gbus_busy, dram_we_n;
	logic transfer_ack_n, autovector_ack_n, core_run, address_strobe_n, read_strobe_n;
	logic upper_write_strobe_n, lower_write_strobe_n, as_seen, uw_seen, lw_seen;
	logic [1:0] ackv;
	logic [2:0] core_fc, interrupt_level_request_n, status_ipl_mask;
	logic [23:0] core_addr, ext_addr;
	logic [15:0] core_wdata, core_rdata, ext_data_in, dram_data_bus_in, cs_wait;
	logic [31:0] boot_ssp, boot_pc;
	logic [3:0] chip_select_n;
	logic [7:0] irq_event;
	logic [26:0] irq_level;
	logic [8:0] event_clear, event_bits;
	int miscompares = 0, tests_run = 0, lat, base;
	core_bus_cycle_control dut (.clk, .reset_n, .core_as_n, .core_rw, .core_byte, .core_fc, .core_addr,
		.core_wdata, .core_rdata, .transfer_ack_n, .autovector_ack_n, .interrupt_level_request_n,
		.status_ipl_mask, .boot_ssp, .boot_pc, .core_run, .cs_wait, .ext_addr, .chip_select_n,
		.address_strobe_n, .read_strobe_n, .upper_write_strobe_n, .lower_write_strobe_n, .ext_data_out(),
		.ext_data_oe(), .ext_data_in, .reg_strobe(), .reg_write(), .reg_rdata(16'h0000), .ext_irq_n,
		.irq_event, .irq_level, .event_clear, .event_bits, .gbus_busy, .dram_row_strobes_n(),
		.dram_column_strobes_n(), .dram_mux_address(), .dram_we_n, .dram_data_out(), .dram_data_oe(),
		.dram_data_bus_in);
	mem_model partner (.clk, .ext_addr, .chip_select_n, .read_strobe_n, .ext_data_in, .dram_data_bus_in);
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic summarize();
		if (miscompares == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize
	task automatic bus(input logic rw, input logic byt, input logic [2:0] fc, input logic [23:0] a);
		@(posedge clk);
		core_as_n <= 1'b0;
		core_rw <= rw;
		core_byte <= byt;
		core_fc <= fc;
		core_addr <= a;
		core_wdata <= 16'hc35a;
		lat = 0;
		{as_seen, uw_seen, lw_seen} = 3'b000;
		do begin
			@(posedge clk);
			lat++;
			as_seen |= !address_strobe_n;
			uw_seen |= !upper_write_strobe_n;
			lw_seen |= !lower_write_strobe_n;
		end while (transfer_ack_n && autovector_ack_n && lat < 60);
		ackv = {transfer_ack_n, autovector_ack_n};
		chk("ack_seen", 1'b1, ackv != 2'h3);
		core_as_n <= 1'b1;
		repeat (2) @(posedge clk);
		chk("ack_release", 2'h3, {transfer_ack_n, autovector_ack_n});
	endtask : bus
	task automatic pulse(input logic [7:0] ev, input logic [8:0] clr);
		@(posedge clk);
		irq_event <= ev;
		event_clear <= clr;
		@(posedge clk);
		irq_event <= 8'h00;
		event_clear <= 9'h000;
		repeat (3) @(posedge clk);
	endtask : pulse
	task automatic boot_check();
		repeat (300) if (core_run !== 1'b1) @(posedge clk);
		chk("run", 1'b1, core_run);
		chk("boot_ssp", {16'h5a3c, 16'h5a3e}, boot_ssp);
		chk("boot_pc", {16'h5a38, 16'h5a3a}, boot_pc);
		chk("mask", 3'h7, status_ipl_mask);
		chk("level", 3'h7, interrupt_level_request_n);
	endtask : boot_check
	task automatic word_timing();
		bus(1'b1, 1'b0, FC_SUP_PROG, 24'h000100);
		base = lat;
		chk("rdata0", 16'h5b3c, core_rdata);
		chk("as_cs", 1'b1, as_seen);
		chk("min_len", 1'b1, lat >= MIN_CYCLES);
		bus(1'b1, 1'b0, FC_SUP_PROG, 24'h200100);
		chk("wait_len", base + 3, lat);
	endtask : word_timing
	task automatic byte_lanes();
		bus(1'b1, 1'b1, FC_SUP_PROG, 24'h000103);
		chk("rd_low", 16'h003e, core_rdata);
		bus(1'b1, 1'b1, FC_SUP_PROG, 24'h000102);
		chk("rd_up", 16'h005b, core_rdata);
		bus(1'b0, 1'b1, FC_SUP_PROG, 24'h000104);
		chk("wr_up", 2'h2, {uw_seen, lw_seen});
		bus(1'b0, 1'b1, FC_SUP_PROG, 24'h000105);
		chk("wr_low", 2'h1, {uw_seen, lw_seen});
	endtask : byte_lanes
	task automatic dram_post();
		gbus_busy <= 1'b1;
		bus(1'b0, 1'b0, FC_SUP_PROG, 24'h800000);
		chk("post_len", MIN_CYCLES, lat);
		chk("as_dram", 1'b0, as_seen);
		fork
			bus(1'b0, 1'b0, FC_SUP_PROG, 24'h800002);
			begin
				repeat (12) @(posedge clk);
				gbus_busy <= 1'b0;
				repeat (2) @(posedge clk);
				chk("dram_we", 1'b0, dram_we_n);
			end
		join
		chk("stall", 1'b1, lat > base + 8);
		repeat (12) @(posedge clk);
		bus(1'b0, 1'b0, FC_SUP_PROG, 24'h800004);
		chk("drained", MIN_CYCLES, lat);
	endtask : dram_post
	task automatic mid_reset();
		ext_irq_n <= 1'b0;
		repeat (5) @(posedge clk);
		chk("ext_event", 9'h001, event_bits);
		chk("ext_lvl", 3'h4, interrupt_level_request_n);
		ext_irq_n <= 1'b1;
		reset_n <= 1'b0;
		repeat (RESET_LATER_CLKS) @(posedge clk);
		chk("rst_events", 9'h000, event_bits);
		reset_n <= 1'b1;
		boot_check();
	endtask : mid_reset
	task automatic interrupts();
		pulse(8'h01, 9'h000);
		chk("event", 9'h002, event_bits);
		chk("lvl5", 3'h2, interrupt_level_request_n);
		bus(1'b1, 1'b0, FC_IACK, {IACK_HIGH, 3'h5, 1'b1});
		chk("autovec", 2'h2, ackv);
		chk("held", 3'h2, interrupt_level_request_n);
		pulse(8'h02, 9'h000);
		chk("lvl6", 3'h1, interrupt_level_request_n);
		pulse(8'h00, 9'h006);
		chk("cleared", 3'h7, interrupt_level_request_n);
	endtask : interrupts
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#100000;
		miscompares++;
		summarize();
	end
	initial begin
		{reset_n, core_rw, core_byte, gbus_busy} = 4'h0;
		{core_as_n, ext_irq_n} = 2'h3;
		{core_fc, core_addr, core_wdata} = '0;
		{irq_event, event_clear} = '0;
		cs_wait = 16'h0030;
		irq_level = {18'h0, 3'h6, 3'h5, 3'h3};
		repeat (RESET_INIT_CLKS) @(posedge clk);
		reset_n <= 1'b1;
		boot_check();
		word_timing();
		byte_lanes();
		dram_post();
		interrupts();
		mid_reset();
		summarize();
	end
endmodule : testbench
`default_nettype wire
